// *** keycmd_top.sv ***
// command handler for private key write, random and read commands
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "keycmd_params.svh"
module keycmd_top (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [9:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  output logic              mac_req,
  output logic [31:0]       mac_header,
  output logic [255:0]      mac_temp_key,
  output logic [287:0]      mac_plain_key,
  output logic [255:0]      mac_value,
  input  wire logic         mac_done,
  input  wire logic         mac_ok,
  input  wire logic [31:0]  tk_hash_prefix,
  input  wire logic         nonce_seed_update
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // state
  keycmd_pkg::state_t state_r;
  keycmd_pkg::state_t state_nxt;
  logic [31:0]  cmd_r;
  logic [7:0]   rc_r;
  logic [5:0]   len_r;
  logic         done_r;
  logic [2:0]   lock_r;
  logic [7:0]   otp_mode_r;
  logic [15:0]  slot_lock_r;
  logic [7:0]   tkf_r;
  logic [255:0] tk_r;
  logic [287:0] val_r;
  logic [255:0] mac_r;
  logic [255:0] rsp_r;
  logic [1023:0] cfg_r;
  logic [511:0] otp_r;
  logic [287:0] slot_r [16];
  logic [287:0] plain_r;
  logic         mac_req_r;
  logic [2:0]   cnt_r;
  logic         ack_r;
  logic [31:0]  rdata_r;
  logic [31:0]  rdata_nxt;
  logic [255:0] rd_blk;
  logic [31:0]  rng_word;

  cmd_ctx_if ctx ();

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle, then the access completes
  wire       req    = avs_read | avs_write;
  wire       acc    = req & !ack_r;
  wire       we     = avs_write & ack_r;
  wire [9:0] ad     = avs_address;
  wire [2:0] wi     = ad[4:2];
  wire [3:0] vi     = ad[5:2];
  wire [4:0] ci     = ad[6:2];
  wire [3:0] oi     = ad[5:2];
  wire       busy   = state_r != keycmd_pkg::ST_IDLE;
  wire       hit_cmd = ad == `A_CMD;
  wire       hit_go  = ad == `A_GO;
  wire       hit_st  = ad == `A_STAT;
  wire       hit_lk  = ad == `A_LOCK;
  wire       hit_tkf = ad == `A_TKF;
  wire       hit_tk  = ad[9:5] == `A_TK_HI;
  wire       hit_val = (ad[9:6] == `A_VAL_HI) & (vi < `VAL_WORDS);
  wire       hit_mac = ad[9:5] == `A_MAC_HI;
  wire       hit_rsp = ad[9:5] == `A_RSP_HI;
  wire       hit_cfg = ad[9:7] == `A_CFG_HI;
  wire       hit_otp = ad[9:6] == `A_OTP_HI;
  wire       go      = we & hit_go & avs_writedata[0] & !busy;
  wire [31:0] lk_new = merge({slot_lock_r, otp_mode_r, 5'h00, lock_r}, avs_writedata, avs_byteenable);

  assign avs_waitrequest = acc;
  assign avs_readdata    = rdata_r;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_cmd) begin
      rdata_nxt = cmd_r;
    end else if (hit_st) begin
      rdata_nxt = {10'h000, len_r, rc_r, 6'h00, done_r, busy};
    end else if (hit_lk) begin
      rdata_nxt = {slot_lock_r, otp_mode_r, 5'h00, lock_r};
    end else if (hit_tkf) begin
      rdata_nxt = {24'h00_0000, tkf_r};
    end else if (hit_tk) begin
      rdata_nxt = tk_r[{wi, 5'h00} +: 32];
    end else if (hit_rsp) begin
      rdata_nxt = rsp_r[{wi, 5'h00} +: 32];
    end else if (hit_cfg) begin
      rdata_nxt = cfg_r[{ci, 5'h00} +: 32];
    end else if (hit_otp) begin
      rdata_nxt = otp_r[{oi, 5'h00} +: 32];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= acc;
      rdata_r <= (acc & avs_read) ? rdata_nxt : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checker and generator
  wire [3:0] slot = ctx.slot_sel;
  wire [9:0] sc_at = `SLOT_CFG_BIT + {2'b00, slot, 4'h0};
  wire [9:0] kc_at = `KEY_CFG_BIT + {2'b00, slot, 4'h0};

  assign ctx.opcode    = cmd_r[7:0];
  assign ctx.param1    = cmd_r[15:8];
  assign ctx.param2    = cmd_r[31:16];
  assign ctx.cfg_lock  = lock_r[0];
  assign ctx.data_lock = lock_r[1];
  assign ctx.otp_lock  = lock_r[2];
  assign ctx.otp_mode  = otp_mode_r;
  assign ctx.slot_lock = slot_lock_r;
  assign ctx.tk_valid  = tkf_r[0];
  assign ctx.tk_digest_generation_command = tkf_r[1];
  assign ctx.tk_rand   = tkf_r[2];
  assign ctx.tk_keyid  = tkf_r[7:4];
  assign ctx.slot_cfg  = cfg_r[sc_at +: 16];
  assign ctx.key_cfg   = cfg_r[kc_at +: 16];

  access_check u_chk (
    .c (ctx.chk)
  );

  wire is_pw  = cmd_r[7:0] == `OP_PRIV_WRITE;
  wire is_rd  = cmd_r[7:0] == `OP_READ;
  wire big    = cmd_r[15];
  wire reseed = (state_r == keycmd_pkg::ST_CHECK) & (ctx.err == `RC_OK) &
                (cmd_r[7:0] == `OP_RANDOM) & !cmd_r[8];

  rng_gen u_rng (
    .clk          (clk),
    .rst_b        (rst_b),
    .cfg_lock     (lock_r[0]),
    .reseed       (reseed),
    .nonce_reseed (nonce_seed_update),
    .word         (rng_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path: whole block fetched in one cycle, beyond slot end reads zero
  function automatic logic [31:0] fetch(input logic [1:0] zn, input logic [4:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (zn == keycmd_pkg::ZN_CFG) begin
      w = cfg_r[{idx, 5'h00} +: 32];
    end else if (zn == keycmd_pkg::ZN_OTP) begin
      w = otp_r[{idx[3:0], 5'h00} +: 32];
    end else if (idx <= `SLOT_WORD_LAST) begin
      w = slot_r[slot][{idx[3:0], 5'h00} +: 32];
    end
    return w;
  endfunction : fetch

  always_comb begin
    rd_blk = 256'h0;
    for (int i = 0; i < 8; i++) begin
      if (i == 0 || big) begin
        rd_blk[i*32 +: 32] = fetch(cmd_r[9:8], ctx.rd_base + 5'(i));
      end
    end
  end

  wire [255:0] rd_out = ctx.rd_enc ? (rd_blk ^ tk_r) : rd_blk;

  // encrypted input is undone in one XOR with the hash prefix and temp key before it is stored
  wire [287:0] plain = ctx.need_mac ? (val_r ^ {tk_hash_prefix, tk_r}) : val_r;

  assign mac_req       = mac_req_r;
  assign mac_header    = cmd_r;
  assign mac_temp_key  = tk_r;
  assign mac_plain_key = plain_r;
  assign mac_value     = mac_r;

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      keycmd_pkg::ST_IDLE: begin
        if (go) begin
          state_nxt = keycmd_pkg::ST_CHECK;
        end
      end
      keycmd_pkg::ST_CHECK: begin
        if (ctx.err != `RC_OK) begin
          state_nxt = keycmd_pkg::ST_DONE;
        end else if (is_pw) begin
          state_nxt = ctx.need_mac ? keycmd_pkg::ST_MAC : keycmd_pkg::ST_WR;
        end else if (is_rd) begin
          state_nxt = keycmd_pkg::ST_DONE;
        end else begin
          state_nxt = keycmd_pkg::ST_RAND;
        end
      end
      keycmd_pkg::ST_MAC: begin
        if (mac_done) begin
          state_nxt = mac_ok ? keycmd_pkg::ST_WR : keycmd_pkg::ST_DONE;
        end
      end
      keycmd_pkg::ST_WR: begin
        state_nxt = keycmd_pkg::ST_DONE;
      end
      keycmd_pkg::ST_RAND: begin
        if (cnt_r == 3'h7) begin
          state_nxt = keycmd_pkg::ST_DONE;
        end
      end
      default: begin
        state_nxt = keycmd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= keycmd_pkg::ST_IDLE;
      rc_r      <= `RC_OK;
      len_r     <= 6'h00;
      done_r    <= 1'b0;
      mac_req_r <= 1'b0;
      cnt_r     <= 3'h0;
      plain_r   <= 288'h0;
      rsp_r     <= 256'h0;
    end else begin
      state_r <= state_nxt;
      // completion wins over a clear in the same cycle
      done_r  <= (state_r == keycmd_pkg::ST_DONE) | (done_r & !go);
      if (go) begin
        len_r <= 6'h00;
      end
      if (state_r == keycmd_pkg::ST_CHECK) begin
        rc_r    <= ctx.err;
        cnt_r   <= 3'h0;
        plain_r <= plain;
        if (ctx.err != `RC_OK) begin
          len_r <= `LEN_RESULT;
          rsp_r <= {248'h0, ctx.err};
        end else if (is_pw) begin
          mac_req_r <= ctx.need_mac;
        end else if (is_rd) begin
          rsp_r <= rd_out;
          len_r <= big ? `LEN_BLOCK : `LEN_WORD;
        end
      end
      if (state_r == keycmd_pkg::ST_MAC && mac_done) begin
        mac_req_r <= 1'b0;
        if (!mac_ok) begin
          rc_r  <= `RC_MAC_FAIL;
          len_r <= `LEN_RESULT;
          rsp_r <= {248'h0, `RC_MAC_FAIL};
        end
      end
      if (state_r == keycmd_pkg::ST_WR) begin
        len_r <= `LEN_RESULT;
        rsp_r <= {248'h0, `RC_OK};
      end
      if (state_r == keycmd_pkg::ST_RAND) begin
        rsp_r[{cnt_r, 5'h00} +: 32] <= rng_word;
        cnt_r <= cnt_r + 3'h1;
        len_r <= (cnt_r == 3'h7) ? `LEN_BLOCK : 6'h00;
      end
    end
  end

  // only the write state touches slot storage, so every failure leaves it intact
  always_ff @(posedge clk) begin
    if (state_r == keycmd_pkg::ST_WR) begin
      slot_r[ctx.slot_sel] <= plain_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-written state; command buffers are frozen while busy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r       <= 32'h0000_0000;
      lock_r      <= 3'h0;
      otp_mode_r  <= 8'h00;
      slot_lock_r <= 16'h0000;
      tkf_r       <= 8'h00;
      tk_r        <= 256'h0;
      val_r       <= 288'h0;
      mac_r       <= 256'h0;
      cfg_r       <= 1024'h0;
      otp_r       <= 512'h0;
    end else if (we) begin
      if (hit_cmd && !busy) begin
        cmd_r <= merge(cmd_r, avs_writedata, avs_byteenable);
      end
      if (hit_lk) begin
        // locks only ever set; the policy byte freezes with the configuration
        lock_r      <= lock_r | lk_new[2:0];
        slot_lock_r <= slot_lock_r | lk_new[31:16];
        otp_mode_r  <= lock_r[0] ? otp_mode_r : lk_new[15:8];
      end
      if (hit_tkf && !busy) begin
        tkf_r <= avs_byteenable[0] ? avs_writedata[7:0] : tkf_r;
      end
      if (hit_tk && !busy) begin
        tk_r[{wi, 5'h00} +: 32] <= merge(tk_r[{wi, 5'h00} +: 32], avs_writedata, avs_byteenable);
      end
      if (hit_val && !busy) begin
        val_r[{vi, 5'h00} +: 32] <= merge(val_r[{vi, 5'h00} +: 32], avs_writedata, avs_byteenable);
      end
      if (hit_mac && !busy) begin
        mac_r[{wi, 5'h00} +: 32] <= merge(mac_r[{wi, 5'h00} +: 32], avs_writedata, avs_byteenable);
      end
      if (hit_cfg && !lock_r[0]) begin
        cfg_r[{ci, 5'h00} +: 32] <= merge(cfg_r[{ci, 5'h00} +: 32], avs_writedata, avs_byteenable);
      end
      if (hit_otp && !lock_r[2]) begin
        otp_r[{oi, 5'h00} +: 32] <= merge(otp_r[{oi, 5'h00} +: 32], avs_writedata, avs_byteenable);
      end
    end
  end
endmodule : keycmd_top

// *** keycmd_params.svh ***
// constants for the key write, random and read command handler
`ifndef KEYCMD_PARAMS_SVH
`define KEYCMD_PARAMS_SVH
`define OP_PRIV_WRITE   8'h46
`define OP_RANDOM       8'h1B
`define OP_READ         8'h02
`define RC_OK           8'h00
`define RC_MAC_FAIL     8'h01
`define RC_PARSE        8'h03
`define RC_EXEC         8'h0F
`define A_CMD           10'h000
`define A_GO            10'h004
`define A_STAT          10'h008
`define A_LOCK          10'h00C
`define A_TKF           10'h010
`define A_TK_HI         5'h01
`define A_VAL_HI        4'h1
`define A_MAC_HI        5'h04
`define A_RSP_HI        5'h05
`define A_CFG_HI        3'h2
`define A_OTP_HI        4'h6
`define VAL_WORDS       4'h9
`define SLOT_WORD_LAST  5'h08
`define SLOT_CFG_BIT    10'h0A0
`define KEY_CFG_BIT     10'h300
`define SC_SECRET       7
`define SC_ENC_READ     6
`define SC_RKEY_LSB     0
`define SC_WKEY_LSB     8
`define SC_WPOL_LSB     12
`define KC_PRIVATE      0
`define WP_ENCRYPT      4'h4
`define LEN_RESULT      6'h01
`define LEN_WORD        6'h04
`define LEN_BLOCK       6'h20
`define RNG_TEST_WORD   32'h0000FFFF
`define RNG_NOISE_RST   32'h0000ACE1
`define RNG_SEED_RST    32'h00000001
`endif

// *** keycmd_pkg.sv ***
// types shared by the command handler modules
package keycmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHECK = 3'b001,
    ST_MAC   = 3'b010,
    ST_WR    = 3'b011,
    ST_RAND  = 3'b100,
    ST_DONE  = 3'b101
  } state_t;
  typedef enum logic [1:0] {
    ZN_CFG  = 2'b00,
    ZN_OTP  = 2'b01,
    ZN_DATA = 2'b10
  } zone_t;
endpackage : keycmd_pkg

// *** cmd_ctx_if.sv ***
// command context passed from the handler to the access checker
`timescale 1ns/100ps
interface cmd_ctx_if;
  logic [7:0]  opcode;
  logic [7:0]  param1;
  logic [15:0] param2;
  logic        cfg_lock;
  logic        data_lock;
  logic        otp_lock;
  logic [7:0]  otp_mode;
  logic [15:0] slot_lock;
  logic        tk_valid;
  logic        tk_digest_generation_command;
  logic        tk_rand;
  logic [3:0]  tk_keyid;
  logic [15:0] slot_cfg;
  logic [15:0] key_cfg;
  logic [3:0]  slot_sel;
  logic [7:0]  err;
  logic        need_mac;
  logic        rd_enc;
  logic [4:0]  rd_base;
  modport handler (output opcode, param1, param2, cfg_lock, data_lock, otp_lock, otp_mode,
                   slot_lock, tk_valid, tk_digest_generation_command, tk_rand, tk_keyid, slot_cfg, key_cfg,
                   input slot_sel, err, need_mac, rd_enc, rd_base);
  modport chk (input opcode, param1, param2, cfg_lock, data_lock, otp_lock, otp_mode,
               slot_lock, tk_valid, tk_digest_generation_command, tk_rand, tk_keyid, slot_cfg, key_cfg,
               output slot_sel, err, need_mac, rd_enc, rd_base);
endinterface : cmd_ctx_if

// *** access_check.sv ***
// parameter and access-policy checks for the three commands
`timescale 1ns/100ps
`include "keycmd_params.svh"
module access_check (
  cmd_ctx_if.chk c
);
  wire        is_pw  = c.opcode == `OP_PRIV_WRITE;
  wire        is_rd  = c.opcode == `OP_READ;
  wire        is_rnd = c.opcode == `OP_RANDOM;
  wire [3:0]  pw_slot = c.param2[3:0];
  wire [1:0]  zone   = c.param1[1:0];
  wire        big    = c.param1[7];
  // 32-byte reads drop the low three word-address bits
  wire [15:0] a      = big ? {c.param2[15:3], 3'b000} : c.param2;
  wire        secret = c.slot_cfg[`SC_SECRET];
  wire        encrd  = c.slot_cfg[`SC_ENC_READ];
  wire [3:0]  wkey   = c.slot_cfg[`SC_WKEY_LSB +: 4];
  wire [3:0]  rkey   = c.slot_cfg[`SC_RKEY_LSB +: 4];
  wire [3:0]  wpol   = c.slot_cfg[`SC_WPOL_LSB +: 4];
  wire        enc_in = c.param1[6];
  // the ready-made nonce flag is looked at for reads only; authorization flags are not looked at here
  wire tk_w_ok = c.tk_valid & c.tk_digest_generation_command & (c.tk_keyid == wkey);
  wire tk_r_ok = c.tk_valid & c.tk_digest_generation_command & c.tk_rand & (c.tk_keyid == rkey);
  wire pw_bad  = c.param1[7] | (|c.param1[5:0]) | (|c.param2[15:4]);
  wire pw_pol  = c.data_lock & (!enc_in | (wpol != `WP_ENCRYPT) | !tk_w_ok);
  wire pw_deny = !c.cfg_lock
               | !c.key_cfg[`KC_PRIVATE] | !secret
               | c.slot_lock[pw_slot]
               | pw_pol;
  wire cfg_in  = a[15:5] == 11'h000;
  wire otp_in  = a[15:4] == 12'h000;
  wire dat_in  = (a[15:11] == 5'h00) & !a[7] & ((a[10:8] == 3'h0) | ((a[10:8] == 3'h1) & (a[2:0] == 3'h0)));
  wire in_rng  = (zone == keycmd_pkg::ZN_CFG) ? cfg_in :
                 (zone == keycmd_pkg::ZN_OTP) ? otp_in :
                 (zone == keycmd_pkg::ZN_DATA) ? dat_in : 1'b0;
  wire rd_bad  = (|c.param1[6:2]) | !in_rng;
  wire otp_deny = !c.otp_lock | ((c.otp_mode != 8'h00) & (a[15:1] == 15'h0000));
  wire dat_deny = !c.data_lock | (secret & !big) | (secret & !encrd) | (encrd & !tk_r_ok);
  wire rd_deny = (zone == keycmd_pkg::ZN_OTP) ? otp_deny :
                 (zone == keycmd_pkg::ZN_DATA) ? dat_deny : 1'b0;
  wire rnd_bad = (|c.param1[7:1]) | (|c.param2);

  assign c.slot_sel = is_pw ? pw_slot : c.param2[6:3];
  assign c.need_mac = enc_in;
  assign c.rd_enc   = (zone == keycmd_pkg::ZN_DATA) & encrd;
  assign c.rd_base  = (zone == keycmd_pkg::ZN_DATA) ? {1'b0, a[8], a[2:0]} : a[4:0];
  assign c.err = is_pw  ? (pw_bad ? `RC_PARSE : pw_deny ? `RC_EXEC : `RC_OK) :
                 is_rd  ? (rd_bad ? `RC_PARSE : rd_deny ? `RC_EXEC : `RC_OK) :
                 is_rnd ? (rnd_bad ? `RC_PARSE : `RC_OK) : `RC_PARSE;
endmodule : access_check

// *** rng_gen.sv ***
// random word source with stored seed shared with the challenge command
`timescale 1ns/100ps
`include "keycmd_params.svh"
module rng_gen (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cfg_lock,
  input  wire logic        reseed,
  input  wire logic        nonce_reseed,
  output logic [31:0]      word
);
  logic [31:0] noise_r;
  logic [31:0] seed_r;
  wire         fb = noise_r[31] ^ noise_r[21] ^ noise_r[1] ^ noise_r[0];

  // free-running noise stands in for the physical entropy source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      noise_r <= `RNG_NOISE_RST;
      seed_r  <= `RNG_SEED_RST;
    end else begin
      noise_r <= {noise_r[30:0], fb};
      if (reseed | nonce_reseed) begin
        seed_r <= seed_r ^ noise_r;
      end
    end
  end

  assign word = cfg_lock ? (noise_r ^ seed_r) : `RNG_TEST_WORD;
endmodule : rng_gen

// *** keycmd_sva.sv ***
// concurrent checks on the bus and hash-engine ports of the command handler
`timescale 1ns/100ps
`include "keycmd_params.svh"
module keycmd_sva (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        mac_req,
  input wire logic [31:0] mac_header,
  input wire logic        mac_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire req = avs_read | avs_write;
  wire rd_ack = avs_read & ~avs_waitrequest;
  ////////////////////////////////////////////////////////////////
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("first access cycle without wait");
  a_wait_one: assert property ($rose(req) |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  a_idle_nowait: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised with no access");
  a_rdata_zero: assert property (!rd_ack |-> avs_readdata == 32'h0)
    else $error("read data outside answer cycle");
  a_mac_hold: assert property (mac_req && !mac_done |=> mac_req)
    else $error("hash request dropped early");
  a_mac_drop: assert property (mac_req && mac_done |=> !mac_req)
    else $error("hash request held after answer");
  a_mac_hdr: assert property (mac_req && !mac_done |=> $stable(mac_header))
    else $error("hash header moved while pending");
  a_mac_enc: assert property ($rose(mac_req) |-> mac_header[7:0] == `OP_PRIV_WRITE && mac_header[14])
    else $error("hash request for plaintext or other command");
endmodule : keycmd_sva
bind keycmd_top keycmd_sva u_sva (.clk(clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mac_req(mac_req),
  .mac_header(mac_header), .mac_done(mac_done));

// *** mac_engine_model.sv ***
// external hash engine: answers each request after a set latency
`timescale 1ns/100ps
module mac_engine_model (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        mac_req,
  input wire logic        verdict,
  input wire logic [3:0]  lat,
  output logic            mac_done,
  output logic            mac_ok,
  output logic [31:0]     tk_hash_prefix
);
  logic [3:0] cnt_r;
  wire fire = mac_req & ~mac_done & (cnt_r == lat);
  assign tk_hash_prefix = 32'h5A3C_0F96;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
      mac_done <= 1'b0;
      mac_ok <= 1'b0;
    end else begin
      cnt_r <= (mac_req && !fire && !mac_done) ? cnt_r + 4'h1 : 4'h0;
      mac_done <= fire;
      // outside the answer cycle the verdict line flips so a stale value is never trusted
      mac_ok <= fire ? verdict : ~mac_ok;
    end
  end
endmodule : mac_engine_model

// *** keycmd_top_tb_top.sv ***
// self-checking bench for the command handler
`timescale 1ns/100ps
`include "keycmd_params.svh"
module keycmd_top_tb_top;
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic        mac_req, mac_done, mac_ok, verdict;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, mac_header, tk_hash_prefix, q;
  logic [3:0]  lat;
  logic        seed_pulse;
  logic [255:0] temp_key, mac_val;
  logic [287:0] plain_key;
  int          err_total, n_checks;
  keycmd_top dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mac_req(mac_req),
    .mac_header(mac_header), .mac_temp_key(temp_key), .mac_plain_key(plain_key), .mac_value(mac_val),
    .mac_done(mac_done), .mac_ok(mac_ok), .tk_hash_prefix(tk_hash_prefix), .nonce_seed_update(seed_pulse));
  mac_engine_model mac_eng (.clk(clk), .rst_b(rst_b), .mac_req(mac_req), .verdict(verdict),
    .lat(lat), .mac_done(mac_done), .mac_ok(mac_ok), .tk_hash_prefix(tk_hash_prefix));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // request held until wait is seen low at a rising edge
  task bus(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task expect_rc(input logic [7:0] op, p1, input logic [15:0] p2, input logic [7:0] rc, input logic [5:0] n);
    logic [31:0] s;
    bus(1'b1, `A_CMD, {p2, p1, op}, s);
    bus(1'b1, `A_GO, 32'h1, s);
    do bus(1'b0, `A_STAT, 32'h0, s); while (s[1:0] !== 2'b10);
    chk({18'h0, s[21:8]}, {18'h0, n, rc});
  endtask : expect_rc
  ////////////////////////////////////////////////////////////////
  task t_unlocked;
    expect_rc(`OP_PRIV_WRITE, 8'h00, 16'h0001, `RC_EXEC, `LEN_RESULT);
    expect_rc(`OP_RANDOM, 8'h00, 16'h0000, `RC_OK, `LEN_BLOCK);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 10'h0A0 + 10'(4 * i), 32'h0, q);
      chk(q, `RNG_TEST_WORD);
    end
    bus(1'b1, 10'h104, 32'h1234_5678, q);
    expect_rc(`OP_READ, 8'h00, 16'h0001, `RC_OK, `LEN_WORD);
    bus(1'b0, 10'h0A0, 32'h0, q);
    chk(q, 32'h1234_5678);
  endtask : t_unlocked
  task t_lock;
    bus(1'b1, 10'h114, 32'h0080_0000, q);
    bus(1'b1, 10'h160, 32'h0001_0000, q);
    bus(1'b1, `A_LOCK, 32'h0000_0001, q);
    bus(1'b1, 10'h104, 32'hDEAD_0000, q);
    expect_rc(`OP_READ, 8'h80, 16'h0007, `RC_OK, `LEN_BLOCK);
    bus(1'b0, 10'h0A4, 32'h0, q);
    chk(q, 32'h1234_5678);
    bus(1'b0, 10'h3FC, 32'h0, q);
    chk(q, 32'h0);
  endtask : t_lock
  task t_params;
    expect_rc(`OP_PRIV_WRITE, 8'h80, 16'h0001, `RC_PARSE, `LEN_RESULT);
    expect_rc(`OP_RANDOM, 8'h02, 16'h0000, `RC_PARSE, `LEN_RESULT);
    expect_rc(`OP_RANDOM, 8'h00, 16'h0001, `RC_PARSE, `LEN_RESULT);
    expect_rc(`OP_READ, 8'h04, 16'h0000, `RC_PARSE, `LEN_RESULT);
    expect_rc(8'h77, 8'h00, 16'h0000, `RC_PARSE, `LEN_RESULT);
    expect_rc(`OP_READ, 8'h01, 16'h0002, `RC_EXEC, `LEN_RESULT);
    expect_rc(`OP_READ, 8'h82, 16'h0008, `RC_EXEC, `LEN_RESULT);
    seed_pulse <= 1'b1;
    @(posedge clk);
    seed_pulse <= 1'b0;
    expect_rc(`OP_RANDOM, 8'h01, 16'h0000, `RC_OK, `LEN_BLOCK);
    bus(1'b0, 10'h0A0, 32'h0, q);
    chk({31'h0, (q === `RNG_TEST_WORD) || $isunknown(q)}, 32'h0);
  endtask : t_params
  task t_key_write;
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, 10'h040 + 10'(4 * i), (i == 0) ? 32'h0 : 32'hA5A5_0000 | 32'(i), q);
    end
    expect_rc(`OP_PRIV_WRITE, 8'h00, 16'h0001, `RC_OK, `LEN_RESULT);
    chk(plain_key[63:32], 32'hA5A5_0001);
    bus(1'b0, 10'h0A0, 32'h0, q);
    chk(q, 32'h0);
    expect_rc(`OP_PRIV_WRITE, 8'h00, 16'h0000, `RC_EXEC, `LEN_RESULT);
    bus(1'b1, 10'h020, 32'h1111_2222, q);
    bus(1'b1, 10'h080, 32'hC0DE_0001, q);
    verdict <= 1'b0;
    lat <= 4'h5;
    expect_rc(`OP_PRIV_WRITE, 8'h40, 16'h0001, `RC_MAC_FAIL, `LEN_RESULT);
    bus(1'b0, 10'h0A0, 32'h0, q);
    chk(q, {24'h00_0000, `RC_MAC_FAIL});
    verdict <= 1'b1;
    lat <= 4'h0;
    expect_rc(`OP_PRIV_WRITE, 8'h40, 16'h0001, `RC_OK, `LEN_RESULT);
    chk(plain_key[31:0], 32'h1111_2222);
    chk(plain_key[287:256], 32'hA5A5_0008 ^ tk_hash_prefix);
    chk(temp_key[31:0], 32'h1111_2222);
    chk(mac_val[31:0], 32'hC0DE_0001);
    bus(1'b1, `A_LOCK, 32'h0002_0001, q);
    expect_rc(`OP_PRIV_WRITE, 8'h00, 16'h0001, `RC_EXEC, `LEN_RESULT);
  endtask : t_key_write
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    err_total++;
    final_report;
  end
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 10'h0;
    avs_writedata = 32'h0;
    verdict = 1'b1;
    lat = 4'h2;
    seed_pulse = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_unlocked;
    t_lock;
    t_params;
    t_key_write;
    final_report;
  end
endmodule : keycmd_top_tb_top
